// *** hdl/cwl_pkg.sv ***
// check weigher package: register map, field layout, defaults, states
package cwl_pkg;
  // data widths and history depth
  localparam int SW = 24;
  localparam int DW = 32;
  localparam int AW = 48;
  localparam int HD = 16;
  localparam int HA = 4;
  localparam int FB = 8;
  localparam int NI = 4;
  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_HIGH  = 8'h04;
  localparam logic [7:0] A_LOW   = 8'h08;
  localparam logic [7:0] A_VAR   = 8'h0C;
  localparam logic [7:0] A_MOT   = 8'h10;
  localparam logic [7:0] A_CTIME = 8'h14;
  localparam logic [7:0] A_CDLY  = 8'h18;
  localparam logic [7:0] A_CHOLD = 8'h1C;
  localparam logic [7:0] A_OFFS  = 8'h20;
  localparam logic [7:0] A_ALIM  = 8'h24;
  localparam logic [7:0] A_OPCT  = 8'h28;
  localparam logic [7:0] A_SPER  = 8'h2C;
  localparam logic [7:0] A_STAT  = 8'h30;
  localparam logic [7:0] A_WGT   = 8'h34;
  localparam logic [7:0] A_DEAD  = 8'h38;
  localparam logic [7:0] A_ACNT  = 8'h3C;
  localparam logic [7:0] A_ISTAT = 8'h40;
  localparam logic [7:0] A_IMASK = 8'h44;
  // control fields: mode [2:0], cutoff [6:4], average count [12:8]
  localparam int C_MODE = 0;
  localparam int C_CUT  = 4;
  localparam int C_NAVG = 8;
  // status word bits
  localparam int B_DRIFT  = 0;
  localparam int B_OVER   = 1;
  localparam int B_VALID  = 2;
  localparam int B_STABLE = 3;
  localparam int B_STATE  = 4;
  localparam int B_DLWIN  = 6;
  // interrupt bits
  localparam int I_RES   = 0;
  localparam int I_DRIFT = 1;
  localparam int I_OVER  = 2;
  localparam int I_DEAD  = 3;
  // reset values; times in microseconds
  localparam logic [31:0] R_CTRL  = 32'h0000_0A30;
  localparam logic [31:0] R_HIGH  = 32'h0000_1000;
  localparam logic [31:0] R_LOW   = 32'h0000_0100;
  localparam logic [31:0] R_VAR   = 32'h0000_0000;
  localparam logic [31:0] R_MOT   = 32'h0000_0010;
  localparam logic [31:0] R_CTIME = 32'h0000_2710;
  localparam logic [31:0] R_CDLY  = 32'h0000_1388;
  localparam logic [31:0] R_CHOLD = 32'h0001_86A0;
  localparam logic [31:0] R_ALIM  = 32'h0000_000A;
  localparam logic [31:0] R_OPCT  = 32'h0000_0014;
  localparam logic [31:0] R_SPER  = 32'h0000_03E8;
  // vibration filter shift per cutoff code, 0 is the 0.25 Hz floor
  localparam logic [3:0] SH_C0 = 4'h8;
  localparam logic [3:0] SH_C1 = 4'h6;
  localparam logic [3:0] SH_C2 = 4'h5;
  localparam logic [3:0] SH_C3 = 4'h4;
  localparam logic [3:0] SH_C4 = 4'h2;
  localparam logic signed [AW-1:0] PCT_FULL = 48'sh64;

  typedef enum logic [2:0] {
    MD_INTERNAL           = 3'h0,
    MD_ONE_EYE_ONE_WINDOW = 3'h1,
    MD_ONE_EYE_TWO_WINDOW = 3'h2,
    MD_TWO_EYE_ONE_WINDOW = 3'h3,
    MD_TWO_EYE_TWO_WINDOW = 3'h4
  } cwl_mode_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_DELAY = 2'b01,
    S_CHECK = 2'b11,
    S_CLEAR = 2'b10
  } cwl_state_t;
endpackage : cwl_pkg

// *** hdl/cwl_hist_mem.sv ***
// weight history memory for the sliding average
`timescale 1ns/1ps
module cwl_hist_mem (
  input  wire logic                         clk,
  input  wire logic                         ce,
  input  wire logic                         we,
  input  wire logic [cwl_pkg::HA-1:0]       waddr,
  input  wire logic signed [cwl_pkg::SW-1:0] wdata,
  input  wire logic                         re,
  input  wire logic [cwl_pkg::HA-1:0]       raddr,
  output logic signed [cwl_pkg::SW-1:0]      rdata
);
  import cwl_pkg::*;

  logic signed [SW-1:0] mem [HD];

  // no reset on the array; the fill count hides stale words
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : cwl_hist_mem

// *** hdl/cwl_top.sv ***
// check weigher cycle logic with AHB-Lite register slave
// Behaviour
// - displayed weight is sliding average of programmable count, default 10
// - vibration filter floor 0.25 Hz, four faster cutoffs, default 7.5 Hz
// - adaptive filter uses variation and motion thresholds; zero variation threshold bypasses
// - check weight averages filtered samples over check time window
// - result held for hold period or until a new object arrives
// - programmed offset subtracted from final check weight
// - internal mode reports loaded weight minus empty-scale weight
// - above high means object present, below low means scale empty
// - drift alarm bit 0 set after programmable cycles without dead load
// - one eye one window waits check delay, then weighs over window
// - stable below low for check time renews dead load, else count up
// - one eye two window measures dead load from trigger until rise/motion
// - override bit flags weight above high by programmable percentage, one eye two window mode only
// - one eye two window starts weighing after check delay expires
// - two eye modes weigh on delay expiry or second eye, first wins
// - two eye one window measures dead load after object passes eye two
// - two eye two window recalculates dead load until eye one sees object
// - dead-load renewal clears alarm count; window end without renewal increments
`timescale 1ns/1ps
module cwl_top (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          ce,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic [31:0]                        hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          sample_valid,
  input  wire logic signed [cwl_pkg::SW-1:0] sample_data,
  input  wire logic                          eye1_in,
  input  wire logic                          eye2_in,
  output logic signed [cwl_pkg::DW-1:0]      check_weight,
  output logic                               result_valid,
  output logic [7:0]                         weigh_status,
  output logic                               irq
);
  import cwl_pkg::*;

  function automatic logic signed [DW-1:0] sdiv(
      input logic signed [AW-1:0] s, input logic [15:0] n);
    logic signed [AW-1:0] q;
    q = (n == 16'h0) ? '0 : s / $signed({1'b0, n});
    return q[DW-1:0];
  endfunction : sdiv

  function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] d);
    return d[DW-1] ? DW'(-d) : d;
  endfunction : mag

  function automatic logic two_eye(input cwl_mode_t m);
    return m == MD_TWO_EYE_ONE_WINDOW || m == MD_TWO_EYE_TWO_WINDOW;
  endfunction : two_eye

  // configuration and bus state
  logic [31:0]          ctrl, ctime, cdly, chold, alim, opct, sper;
  logic signed [DW-1:0] high_thd, low_thd, var_thd, mot_thd, offs;
  logic [NI-1:0]        istat, imask, ev, w1c;
  logic                 dp_wr;
  logic [7:0]           dp_addr;
  logic [31:0]          rd_val;
  cwl_mode_t            mode;
  logic [3:0]           cut_sh;
  logic [4:0]           navg;
  logic                 acc, hi_ok, clr_hist;

  assign acc       = hsel & htrans[1] & hready;
  assign hi_ok     = haddr[31:8] == 24'h0;
  assign hreadyout = ce;  // frozen block stalls the bus
  assign hresp     = 1'b0;
  assign clr_hist  = ce & dp_wr & (dp_addr == A_CTRL);
  assign w1c = (dp_wr && dp_addr == A_ISTAT) ? hwdata[NI-1:0] : '0;

  // field decode; illegal mode codes act as internal mode
  always_comb begin
    mode = MD_INTERNAL;
    if (ctrl[C_MODE+:3] <= 3'h4) begin
      mode = cwl_mode_t'(ctrl[C_MODE+:3]);
    end
    navg = ctrl[C_NAVG+:5];
    if (navg == 5'h00) begin
      navg = 5'h01;
    end else if (navg > 5'h10) begin
      navg = 5'h10;
    end
    unique case (ctrl[C_CUT+:3])
      3'h0:    cut_sh = SH_C0;
      3'h1:    cut_sh = SH_C1;
      3'h2:    cut_sh = SH_C2;
      3'h3:    cut_sh = SH_C3;
      default: cut_sh = SH_C4;
    endcase
  end

  // address phase capture; hsize ignored, whole words only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else if (ce && hready) begin
      dp_wr   <= acc & hwrite & hi_ok;
      dp_addr <= haddr[7:0];
      hrdata  <= (acc && !hwrite && hi_ok) ? rd_val : 32'h0000_0000;
    end
  end

  // software-written registers, taken in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl     <= R_CTRL;
      high_thd <= R_HIGH;
      low_thd  <= R_LOW;
      var_thd  <= R_VAR;
      mot_thd  <= R_MOT;
      ctime    <= R_CTIME;
      cdly     <= R_CDLY;
      chold    <= R_CHOLD;
      offs     <= '0;
      alim     <= R_ALIM;
      opct     <= R_OPCT;
      sper     <= R_SPER;
      imask    <= '0;
    end else if (ce && dp_wr) begin
      case (dp_addr)
        A_CTRL:  ctrl     <= hwdata;
        A_HIGH:  high_thd <= hwdata;
        A_LOW:   low_thd  <= hwdata;
        A_VAR:   var_thd  <= hwdata;
        A_MOT:   mot_thd  <= hwdata;
        A_CTIME: ctime    <= hwdata;
        A_CDLY:  cdly     <= hwdata;
        A_CHOLD: chold    <= hwdata;
        A_OFFS:  offs     <= hwdata;
        A_ALIM:  alim     <= hwdata;
        A_OPCT:  opct     <= hwdata;
        A_SPER:  sper     <= hwdata;
        A_IMASK: imask    <= hwdata[NI-1:0];
        default: ;
      endcase
    end
  end

  // photo-eye synchronisers, level taken once two stages agree
  logic [1:0] eye_in, eye_lvl, eye_prev;
  assign eye_in = {eye2_in, eye1_in};
  for (genvar g = 0; g < 2; g++) begin : g_eye
    logic [2:0] sh;
    logic       lvl;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sh  <= 3'h0;
        lvl <= 1'b0;
      end else if (ce) begin
        sh <= {sh[1:0], eye_in[g]};
        if (sh[1] == sh[2]) begin
          lvl <= sh[2];
        end
      end
    end
    assign eye_lvl[g] = lvl;
  end

  // filter pipeline: a vibration, b history, c mean, d adaptive
  logic                 va, vb, vc, ft, primed, moving, take;
  logic signed [DW-1:0] vib, avg, avg_prev, wf;
  logic signed [SW-1:0] vib_w, old_w;
  logic [HA-1:0]        wptr, raddr;
  logic [4:0]           fill;
  logic signed [AW-1:0] hsum;

  // a sample right behind an accepted one is dropped
  assign take  = sample_valid & ~va;
  assign vib_w = vib[FB+SW-1:FB];
  assign raddr = wptr - navg[HA-1:0];

  // first-order low-pass, shift sets the cutoff
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vib    <= '0;
      va     <= 1'b0;
      primed <= 1'b0;
    end else if (ce) begin
      va <= take;
      if (take) begin
        primed <= 1'b1;
        vib <= primed
             ? vib + (($signed({sample_data, {FB{1'b0}}}) - vib) >>> cut_sh)
             : $signed({sample_data, {FB{1'b0}}});
      end
    end
  end

  cwl_hist_mem u_hist (
    .clk   (hclk),
    .ce    (ce),
    .we    (va),
    .waddr (wptr),
    .wdata (vib_w),
    .re    (take),
    .raddr (raddr),
    .rdata (old_w)
  );

  // running sum drops the word leaving the window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr <= '0;
      fill <= 5'h00;
      hsum <= '0;
      vb   <= 1'b0;
    end else if (clr_hist) begin
      wptr <= '0;
      fill <= 5'h00;
      hsum <= '0;
      vb   <= 1'b0;
    end else if (ce) begin
      vb <= va;
      if (va) begin
        wptr <= wptr + 1'b1;
        if (fill == navg) begin
          hsum <= hsum + vib_w - old_w;
        end else begin
          hsum <= hsum + vib_w;
          fill <= fill + 5'h01;
        end
      end
    end
  end

  // mean over words held so far
  // adaptive stage, zero variation threshold passes mean through
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vc       <= 1'b0;
      ft       <= 1'b0;
      avg      <= '0;
      wf       <= '0;
      avg_prev <= '0;
      moving   <= 1'b0;
    end else if (ce) begin
      vc <= vb;
      ft <= vc;
      if (vb) begin
        avg <= sdiv(hsum, {11'h000, fill});
      end
      if (vc) begin
        avg_prev <= avg;
        moving   <= mag(avg - avg_prev) > mot_thd;
        if (var_thd == '0 || mag(avg - wf) > var_thd) begin
          wf <= avg;
        end else if (mag(avg - wf) > mot_thd) begin
          wf <= wf + ((avg - wf) >>> 1);
        end
      end
    end
  end

  // per-tick decisions on the filtered weight
  cwl_state_t           st;
  logic                 below, above, stb, start, dly_done, fin, new_obj;
  logic                 e1_rise, e2_rise, e2_fall;
  logic [31:0]          tcnt, nt, dt, hcnt;
  logic signed [AW-1:0] cacc, dacc, lim;
  logic [15:0]          cn, dn, acnt;
  logic signed [DW-1:0] dead_load, net;
  logic                 dl_win, dl_done, dl_open, dl_close, dl_upd;
  logic                 drift, over, over_now;

  assign below   = wf < low_thd;
  assign above   = wf > high_thd;
  assign stb     = ~moving;
  // eye edges seen only at the filtered sample tick
  assign e1_rise = ft & eye_lvl[0] & ~eye_prev[0];
  assign e2_rise = ft & eye_lvl[1] & ~eye_prev[1];
  assign e2_fall = ft & ~eye_lvl[1] & eye_prev[1];
  // internal mode starts on a stable load
  assign start   = (mode == MD_INTERNAL) ? ft & above & stb : e1_rise;
  assign new_obj = (st == S_IDLE) & start;
  assign nt      = tcnt + sper;
  // same delay start in the two-window variant
  // second eye cuts the delay short
  assign dly_done = (mode == MD_INTERNAL) | (nt >= cdly)
                  | (two_eye(mode) & e2_rise);
  // window closes once elapsed time reaches check time
  assign fin = ft & (st == S_CHECK) & (nt >= ctime);
  // loaded mean less the empty-scale weight
  assign net = sdiv(cacc + wf, cn + 16'h0001) - dead_load;
  assign lim = high_thd + (high_thd * $signed({40'h0, opct[7:0]})) / PCT_FULL;
  // override only in the one eye two window mode
  assign over_now = (mode == MD_ONE_EYE_TWO_WINDOW) && (net > lim);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eye_prev <= 2'b00;
    end else if (ce && ft) begin
      eye_prev <= eye_lvl;
    end
  end

  // weigh cycle state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st   <= S_IDLE;
      tcnt <= '0;
      cacc <= '0;
      cn   <= 16'h0000;
    end else if (ce && ft) begin
      unique case (st)
        S_IDLE: begin
          tcnt <= '0;
          if (start) begin
            st <= S_DELAY;
          end
        end
        S_DELAY: begin
          if (dly_done) begin
            st   <= S_CHECK;
            tcnt <= '0;
            cacc <= '0;
            cn   <= 16'h0000;
          end else begin
            tcnt <= nt;
          end
        end
        // accumulate one filtered sample per tick
        S_CHECK: begin
          cacc <= cacc + wf;
          cn   <= cn + 16'h0001;
          tcnt <= nt;
          if (nt >= ctime) begin
            st <= (mode == MD_INTERNAL) ? S_CLEAR : S_IDLE;
          end
        end
        // wait for a stable empty scale
        S_CLEAR: begin
          if (below && stb) begin
            st <= S_IDLE;
          end
        end
      endcase
    end
  end

  // result register with hold timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      check_weight <= '0;
      result_valid <= 1'b0;
      over         <= 1'b0;
      hcnt         <= '0;
    end else if (ce) begin
      if (fin) begin
        check_weight <= net - offs;
        result_valid <= 1'b1;
        over         <= over_now;
        hcnt         <= '0;
      // hold ends on timeout or next object
      end else if (result_valid && (new_obj || (ft && hcnt + sper >= chold)))
      begin
        check_weight <= '0;
        result_valid <= 1'b0;
        over         <= 1'b0;
      end else if (result_valid && ft) begin
        hcnt <= hcnt + sper;
      end
    end
  end

  // dead-load window bounds per mode
  always_comb begin
    dl_open  = 1'b0;
    dl_close = 1'b0;
    unique case (mode)
      // open while idle, closed by the next object
      MD_INTERNAL, MD_ONE_EYE_ONE_WINDOW: begin
        dl_open  = ft & (st == S_IDLE);
        dl_close = new_obj;
      end
      // trigger on quiet empty scale, stop on rise or motion
      MD_ONE_EYE_TWO_WINDOW: begin
        dl_open  = e1_rise & below & stb;
        dl_close = ft & ~(below & stb);
      end
      // after eye two clears, until eye one sees the next
      // same bounds when the last object has left
      default: begin
        dl_open  = e2_fall;
        dl_close = e1_rise;
      end
    endcase
  end

  // only quiet samples below low count; motion restarts the run
  assign dl_upd = dl_win & ft & below & stb & (dt + sper >= ctime);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dl_win    <= 1'b0;
      dl_done   <= 1'b0;
      dead_load <= '0;
      dacc      <= '0;
      dn        <= 16'h0000;
      dt        <= '0;
      acnt      <= 16'h0000;
    end else if (ce) begin
      if (dl_win && dl_close) begin
        dl_win <= 1'b0;
        // failed window bumps the count, saturating
        if (!dl_done && acnt != 16'hFFFF) begin
          acnt <= acnt + 16'h0001;
        end
      end else if (!dl_win && dl_open) begin
        dl_win  <= 1'b1;
        dl_done <= 1'b0;
        dacc    <= '0;
        dn      <= 16'h0000;
        dt      <= '0;
      end else if (dl_win && ft) begin
        if (!(below && stb)) begin
          dacc <= '0;
          dn   <= 16'h0000;
          dt   <= '0;
        end else if (dl_upd) begin
          // new dead load clears the alarm count
          dead_load <= sdiv(dacc + wf, dn + 16'h0001);
          dl_done   <= 1'b1;
          acnt      <= 16'h0000;
          dacc      <= '0;
          dn        <= 16'h0000;
          dt        <= '0;
        end else begin
          dacc <= dacc + wf;
          dn   <= dn + 16'h0001;
          dt   <= dt + sper;
        end
      end
    end
  end

  // status word and sticky interrupt flags; a set beats a clear
  always_comb begin
    ev          = '0;
    ev[I_RES]   = fin;
    ev[I_DRIFT] = (alim[15:0] != 16'h0000) & (acnt >= alim[15:0]) & ~drift;
    ev[I_OVER]  = fin & over_now;
    ev[I_DEAD]  = dl_upd;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drift        <= 1'b0;
      istat        <= '0;
      weigh_status <= 8'h00;
    end else if (ce) begin
      // drift alarm once the count reaches the limit
      drift <= (alim[15:0] != 16'h0000) && (acnt >= alim[15:0]);
      istat <= (istat & ~w1c) | ev;
      weigh_status               <= 8'h00;
      weigh_status[B_DRIFT]      <= drift;
      weigh_status[B_OVER]       <= over;
      weigh_status[B_VALID]      <= result_valid;
      weigh_status[B_STABLE]     <= stb;
      weigh_status[B_STATE+:2]   <= st;
      weigh_status[B_DLWIN]      <= dl_win;
    end
  end

  assign irq = |(istat & imask);

  // read mux; unmapped words read zero
  always_comb begin
    case (haddr[7:0])
      A_CTRL:  rd_val = ctrl;
      A_HIGH:  rd_val = high_thd;
      A_LOW:   rd_val = low_thd;
      A_VAR:   rd_val = var_thd;
      A_MOT:   rd_val = mot_thd;
      A_CTIME: rd_val = ctime;
      A_CDLY:  rd_val = cdly;
      A_CHOLD: rd_val = chold;
      A_OFFS:  rd_val = offs;
      A_ALIM:  rd_val = alim;
      A_OPCT:  rd_val = opct;
      A_SPER:  rd_val = sper;
      A_STAT:  rd_val = {24'h000000, weigh_status};
      A_WGT:   rd_val = check_weight;
      A_DEAD:  rd_val = dead_load;
      A_ACNT:  rd_val = {16'h0000, acnt};
      A_ISTAT: rd_val = {{(32-NI){1'b0}}, istat};
      A_IMASK: rd_val = {{(32-NI){1'b0}}, imask};
      default: rd_val = 32'h0000_0000;
    endcase
  end
endmodule : cwl_top

// *** tb/cwl_assertions.sv ***
// port checker for the check weigher, bound to the top
`timescale 1ns/1ps
module cwl_assertions (
  input wire logic                          hclk,
  input wire logic                          hresetn,
  input wire logic                          ce,
  input wire logic                          hreadyout,
  input wire logic                          hresp,
  input wire logic signed [cwl_pkg::DW-1:0] check_weight,
  input wire logic                          result_valid,
  input wire logic [7:0]                    weigh_status
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // result edge, check state on status, then valid echoed
  sequence s_new;
    $rose(result_valid);
  endsequence
  sequence s_shown;
    weigh_status[5:4] == 2'b11 ##1 weigh_status[2];
  endsequence
  okay_resp_a:
    assert property (hresp == 1'b0)
    else $error("response not okay");
  ready_ce_a:
    assert property (hreadyout == ce)
    else $error("ready does not follow enable");
  zero_idle_a:
    assert property (!result_valid |-> check_weight == 0)
    else $error("weight shown without result");
  hold_steady_a:
    assert property (result_valid && $past(result_valid)
      |-> $stable(check_weight))
    else $error("held weight moved");
  valid_echo_a:
    assert property ($past(ce)
      |-> weigh_status[2] == $past(result_valid))
    else $error("status valid bit wrong");
  top_zero_a:
    assert property (weigh_status[7] == 1'b0)
    else $error("status bit 7 set");
  ce_freeze_a:
    assert property (!ce |=> $stable(check_weight)
      && $stable(result_valid) && $stable(weigh_status))
    else $error("state moved while disabled");
  result_check_a:
    assert property (s_new |-> s_shown)
    else $error("result outside check window");
endmodule : cwl_assertions
bind cwl_top cwl_assertions u_chk (.hclk, .hresetn, .ce, .hreadyout,
  .hresp, .check_weight, .result_valid, .weigh_status);

// *** tb/cwl_src.sv ***
// load cell sample stream and photo-eye source model
`timescale 1ns/1ps
module cwl_src (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic signed [cwl_pkg::SW-1:0] wgt,
  input  wire logic [1:0]                    eyes,
  output logic                               sample_valid,
  output logic signed [cwl_pkg::SW-1:0]      sample_data,
  output logic                               eye1_in,
  output logic                               eye2_in
);
  logic [2:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 3'h0;
      sample_valid <= 1'b0;
      sample_data <= '0;
    end else begin
      cnt <= cnt + 3'h1;
      sample_valid <= (cnt == 3'h0);
      // off the strobe the line carries junk, not the last value
      sample_data <= (cnt == 3'h0) ? wgt : ~wgt;
    end
  end
  // eyes are raw levels; the design syncs them
  assign eye1_in = eyes[0];
  assign eye2_in = eyes[1];
endmodule : cwl_src

// *** tb/cwl_top_tb.sv ***
// bench: bus setup, weigh cycles per mode, alarm count
`timescale 1ns/1ps
module cwl_top_tb;
  import cwl_pkg::*;
  logic               hclk, hresetn, ce, hsel, hwrite, hrdy, hresp;
  logic               rv, irq, sv, e1, e2;
  logic [31:0]        haddr, hwdata, hrdata, d;
  logic [1:0]         htrans, eyes;
  logic [7:0]         ws;
  logic signed [23:0] wgt, sd;
  logic signed [31:0] cw;
  int                 fail_count, samples_checked, cyc, n;

  always #2 hclk = ~hclk;
  cwl_src src (.hclk, .hresetn, .wgt, .eyes, .sample_valid(sv),
    .sample_data(sd), .eye1_in(e1), .eye2_in(e2));
  cwl_top dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hrdy), .hrdata, .hreadyout(hrdy),
    .hresp, .sample_valid(sv), .sample_data(sd), .eye1_in(e1),
    .eye2_in(e2), .check_weight(cw), .result_valid(rv),
    .weigh_status(ws), .irq);

  // one single AHB-Lite transfer; master waits, never counts
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= v;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask : xfer

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask : chk

  // filter rounding leaves a small residue, so allow a band
  task near(input string s, input logic signed [31:0] e, g);
    samples_checked++;
    if ((g >= e - 64 && g <= e + 64) !== 1'b1) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask : near

  // bounded wait for the result flag to reach a level
  task wv(input logic lv);
    n = 0;
    while (rv !== lv && n < 4000) begin
      @(posedge hclk);
      n++;
    end
    // a wait that runs out is a failure in its own right
    if (rv !== lv) begin
      fail_count++;
      $display("ERROR result_valid wait exp %b got %b", lv, rv);
    end
  endtask : wv

  task final_report;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      final_report;
    end
  end

  // main sequence
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, eyes} = '0;
    {haddr, hwdata, cyc, fail_count, samples_checked} = '0;
    ce = 1'b1;
    wgt = 24'h80;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, A_CTRL, 0);
    chk("ctrl", R_CTRL, d);
    xfer(1'b0, A_VAR, 0);
    chk("var", R_VAR, d);
    xfer(1'b0, 8'h80, 0);
    chk("unmapped", 0, d);
    ce <= 1'b0;
    repeat (4) @(posedge hclk);
    ce <= 1'b1;
    xfer(1'b1, A_SPER, 1);
    xfer(1'b1, A_CTIME, 4);
    xfer(1'b1, A_CDLY, 60);
    xfer(1'b1, A_CHOLD, 40);
    xfer(1'b1, A_OFFS, 32'h100);
    xfer(1'b1, A_ALIM, 1);
    xfer(1'b1, A_IMASK, 1);
    // each mode: empty, load, eye1, eye2 soon after
    for (int m = 0; m < 5; m++) begin
      xfer(1'b1, A_CTRL, 32'h140 + 32'(m));
      wgt <= 24'h80;
      repeat (240) @(posedge hclk);
      wgt <= 24'h3080;
      repeat (240) @(posedge hclk);
      eyes <= 2'b01;
      repeat (40) @(posedge hclk);
      eyes <= 2'b11;
      wv(1'b1);
      @(posedge hclk);
      chk("delay", 32'(m == 1 || m == 2), 32'(n >= 400));
      near("weight", 32'sh2F00, cw);
      chk("over", 32'(m == 2), 32'(ws[1]));
      chk("irq", 1, 32'(irq));
      xfer(1'b1, A_ISTAT, 32'hF);
      // the clear lands on the closing edge; look one edge later
      @(posedge hclk);
      chk("irq_clr", 0, 32'(irq));
      eyes <= 2'b00;
      wgt <= 24'h80;
      wv(1'b0);
      chk("cleared", 0, cw);
    end
    // second object before any dead-load renewal
    xfer(1'b1, A_CTRL, 32'h141);
    repeat (240) @(posedge hclk);
    wgt <= 24'h3080;
    repeat (240) @(posedge hclk);
    eyes <= 2'b01;
    wv(1'b1);
    eyes <= 2'b00;
    repeat (80) @(posedge hclk);
    eyes <= 2'b01;
    repeat (80) @(posedge hclk);
    chk("new_obj", 0, 32'(rv));
    xfer(1'b0, A_ACNT, 0);
    chk("acnt", 1, d);
    chk("drift", 1, 32'(ws[0]));
    xfer(1'b1, A_ISTAT, 1);
    xfer(1'b0, A_ISTAT, 0);
    chk("istat", 32'hA, d);
    chk("masked", 0, 32'(irq));
    wv(1'b1);
    wgt <= 24'h80;
    repeat (400) @(posedge hclk);
    xfer(1'b0, A_ACNT, 0);
    chk("renew", 0, d);
    chk("drift_off", 0, 32'(ws[0]));
    final_report;
  end
endmodule : cwl_top_tb
